//--- verilog/pmap_pkg.sv
// constants and types for the programmer segment map register bank
`default_nettype none
package pmap_pkg;
  localparam int IDX_W = 14;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int PROG_W = 2;
  localparam int GEN_OFF_W = 6;
  localparam int SEG_NUM_W = 6;
  localparam int SEG_PARAM_W = 5;
  localparam int GEN_ENTRIES = 512;
  localparam int SEG_ENTRIES = 16384;
  localparam logic [DATA_W-1:0] PROG_COUNT = 16'h0004;
  localparam logic [DATA_W-1:0] SEL_RESET = 16'h0000;
  localparam logic [IDX_W-1:0] CTRL_IDX = 14'h0000;
  localparam logic [IDX_W-1:0] STATUS_IDX = 14'h0001;
  localparam logic [IDX_W-1:0] PROG1_GEN_BASE = 14'h1440;
  localparam logic [IDX_W-1:0] PROG2_GEN_BASE = 14'h1480;
  localparam logic [IDX_W-1:0] GEN_RSVD_BASE = 14'h14C0;
  localparam logic [IDX_W-1:0] SEG1_BASE = 14'h1500;
  localparam logic [IDX_W-1:0] SEG2_BASE = 14'h1B40;
  localparam logic [IDX_W-1:0] SEG2_LAST_BASE = 14'h2160;
  localparam logic [IDX_W-1:0] SEG_RSVD_BASE = 14'h2180;
  localparam logic [IDX_W-1:0] SEG_RSVD_LAST = 14'h27BF;
  localparam logic [SEG_NUM_W-1:0] SEG_LAST = 6'h31;
  localparam logic [IDX_W-1:0] PROG1_PROGRAM_SELECT_IDX = 14'h1440;
  localparam logic [IDX_W-1:0] PROG1_POWER_FAIL_ACTION_IDX = 14'h1445;
  localparam logic [IDX_W-1:0] PROG2_PROGRAM_SELECT_IDX = 14'h1480;
  localparam logic [IDX_W-1:0] PROG2_POWER_FAIL_ACTION_IDX = 14'h1485;
  localparam logic [IDX_W-1:0] PROG1_SEG1_KIND_IDX = 14'h1500;
  localparam logic [IDX_W-1:0] PROG1_SEG1_TARGET_SETPOINT_IDX = 14'h1506;
  localparam logic [IDX_W-1:0] PROG1_SEG2_KIND_IDX = 14'h1520;
  localparam logic [IDX_W-1:0] PROG2_SEG1_KIND_IDX = 14'h1B40;
  localparam logic [IDX_W-1:0] PROG2_SEG1_TARGET_SETPOINT_IDX = 14'h1B46;
  localparam logic [IDX_W-1:0] PROG2_SEG2_KIND_IDX = 14'h1B60;
  localparam logic [GEN_OFF_W-1:0] PROGRAM_SELECT_OFF = 6'h00;
  localparam logic [GEN_OFF_W-1:0] POWER_FAIL_ACTION_OFF = 6'h05;
  localparam logic [GEN_OFF_W-1:0] SEG_KIND_OFF = 6'h00;
  localparam logic [GEN_OFF_W-1:0] SEGMENT_TARGET_SETPOINT_OFF = 6'h06;
  localparam int CTRL_SYNC_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    RG_NONE = 3'h0,
    RG_CTRL = 3'h1,
    RG_STAT = 3'h2,
    RG_GEN = 3'h3,
    RG_SEG = 3'h4,
    RG_RSVD = 3'h5
  } pmap_region_e;
  typedef enum logic {
    WS_IDLE = 1'b0,
    WS_RESP = 1'b1
  } pmap_wstate_e;
  typedef struct packed {
    pmap_region_e region;
    logic prog2;
    logic [SEG_NUM_W-1:0] seg;
    logic [GEN_OFF_W-1:0] off;
  } pmap_dec_s;
endpackage
`default_nettype wire

//--- verilog/pmap_regs.sv
// axi4-lite register bank mapping both programmers' general and segment areas
`timescale 1ns/1ps
`default_nettype none
module pmap_regs
  import pmap_pkg::*;
(
  input wire logic aclk, // 50 MHz clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [ADDR_W-1:0] awaddr, // write byte address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [ADDR_W-1:0] araddr, // read byte address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic sync_mode, // programmer two slaved to one
  output logic [PROG_W-1:0] prog1_active_program, // program seen by one
  output logic [PROG_W-1:0] prog2_active_program // program seen by two
);

  logic sync_reg;
  logic [DATA_W-1:0] sel_reg [2];
  logic [DATA_W-1:0] gen_mem [GEN_ENTRIES];
  logic [DATA_W-1:0] seg_mem [SEG_ENTRIES];
  pmap_wstate_e wstate_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [IDX_W-1:0] awidx_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [1:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_go;
  pmap_dec_s wr_dec;
  pmap_dec_s rd_dec;
  logic [31:0] wr_old;
  logic [DATA_W-1:0] wr_val;
  logic [1:0] wr_resp;
  logic wr_ctrl_en;
  logic wr_sel_en;
  logic wr_gen_en;
  logic wr_seg_en;

  // byte addresses are four times the printed word index
  function automatic pmap_dec_s pmap_decode(input logic [IDX_W-1:0] idx);
    pmap_dec_s d;
    logic [IDX_W-1:0] rel;
    d = '0;
    rel = '0;
    if (idx == CTRL_IDX)
      d.region = RG_CTRL;
    else if (idx == STATUS_IDX)
      d.region = RG_STAT;
    else if (idx >= PROG1_GEN_BASE && idx < GEN_RSVD_BASE)
    begin
      rel = idx - PROG1_GEN_BASE;
      d.region = RG_GEN;
      d.prog2 = rel[GEN_OFF_W];
      d.off = rel[GEN_OFF_W-1:0];
    end
    else if (idx >= GEN_RSVD_BASE && idx < SEG1_BASE)
      d.region = RG_RSVD;
    else if (idx >= SEG1_BASE && idx < SEG2_BASE)
    begin
      rel = idx - SEG1_BASE;
      d.region = RG_SEG;
      d.seg = rel[SEG_NUM_W+SEG_PARAM_W-1:SEG_PARAM_W];
      d.off = {1'b0, rel[SEG_PARAM_W-1:0]};
    end
    else if (idx >= SEG2_BASE && idx < SEG_RSVD_BASE)
    begin
      rel = idx - SEG2_BASE;
      d.region = RG_SEG;
      d.prog2 = 1'b1;
      d.seg = rel[SEG_NUM_W+SEG_PARAM_W-1:SEG_PARAM_W];
      d.off = {1'b0, rel[SEG_PARAM_W-1:0]};
    end
    else if (idx >= SEG_RSVD_BASE && idx <= SEG_RSVD_LAST)
      d.region = RG_RSVD;
    return d;
  endfunction

  // in synchronous mode one program drives both channels
  function automatic logic [PROG_W-1:0] eff_prog(input logic p);
    if (sync_reg || !p)
      return sel_reg[0][PROG_W-1:0];
    return sel_reg[1][PROG_W-1:0];
  endfunction

  function automatic logic [31:0] rd_word(input pmap_dec_s d);
    logic [31:0] r;
    r = '0;
    case (d.region)
      RG_CTRL: r = 32'(sync_reg);
      RG_STAT: r = 32'({eff_prog(1'b1), eff_prog(1'b0), sync_reg});
      RG_GEN:
      begin
        if (d.off == PROGRAM_SELECT_OFF)
          r = 32'(sel_reg[d.prog2]);
        else
          r = 32'(gen_mem[{d.prog2, eff_prog(d.prog2), d.off}]);
      end
      RG_SEG: r = 32'(seg_mem[{d.prog2, eff_prog(d.prog2), d.seg,
                               d.off[SEG_PARAM_W-1:0]}]);
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw, input logic [1:0] strb);
    logic [DATA_W-1:0] m;
    m = old;
    for (int b = 0; b < DATA_W / BYTE_W; b++)
    begin
      if (strb[b])
        m[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
    end
    return m;
  endfunction

  assign wr_go = (wstate_reg == WS_IDLE) && aw_held_reg && w_held_reg;
  assign wr_dec = pmap_decode(awidx_reg);
  assign rd_dec = pmap_decode(araddr[IDX_W+1:2]);
  // a continuous assign would not wake on the registers and memories read inside the functions
  always_comb
  begin
    wr_old = rd_word(wr_dec);
    prog1_active_program = eff_prog(1'b0);
    prog2_active_program = eff_prog(1'b1);
  end

  always_comb
  begin
    wr_val = merge(wr_old[DATA_W-1:0], wdata_reg, wstrb_reg);
    wr_resp = RESP_OKAY;
    wr_ctrl_en = 1'b0;
    wr_sel_en = 1'b0;
    wr_gen_en = 1'b0;
    wr_seg_en = 1'b0;
    case (wr_dec.region)
      RG_CTRL: wr_ctrl_en = 1'b1;
      RG_STAT: wr_resp = RESP_SLVERR;
      RG_GEN:
      begin
        if (wr_dec.off != PROGRAM_SELECT_OFF)
          wr_gen_en = 1'b1;
        else if (wr_val < PROG_COUNT)
          wr_sel_en = 1'b1;
        else
          wr_resp = RESP_SLVERR;
      end
      RG_SEG: wr_seg_en = 1'b1;
      RG_RSVD: wr_resp = RESP_SLVERR;
      default: wr_resp = RESP_DECERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_reg <= 1'b0;
      sel_reg[0] <= SEL_RESET;
      sel_reg[1] <= SEL_RESET;
    end
    else if (wr_go)
    begin
      if (wr_ctrl_en)
        sync_reg <= wr_val[CTRL_SYNC_BIT];
      if (wr_sel_en)
        sel_reg[wr_dec.prog2] <= wr_val;
    end
  end

  // parameter storage is plain data and is not cleared by reset
  always_ff @(posedge aclk)
  begin
    if (wr_go && wr_gen_en)
      gen_mem[{wr_dec.prog2, eff_prog(wr_dec.prog2), wr_dec.off}] <= wr_val;
    if (wr_go && wr_seg_en)
      seg_mem[{wr_dec.prog2, eff_prog(wr_dec.prog2), wr_dec.seg,
               wr_dec.off[SEG_PARAM_W-1:0]}] <= wr_val;
  end

  // address and data are held separately so either may come first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate_reg <= WS_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awidx_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_reg <= 1'b1;
        awidx_reg <= awaddr[IDX_W+1:2];
      end
      if (wvalid && wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata[DATA_W-1:0];
        wstrb_reg <= wstrb[1:0];
      end
      case (wstate_reg)
        WS_IDLE:
        begin
          if (wr_go)
          begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bresp_reg <= wr_resp;
            wstate_reg <= WS_RESP;
          end
        end
        WS_RESP:
        begin
          if (bready)
            wstate_reg <= WS_IDLE;
        end
        default: wstate_reg <= WS_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word(rd_dec);
      if (rd_dec.region == RG_RSVD)
        rresp_reg <= RESP_SLVERR;
      else if (rd_dec.region == RG_NONE)
        rresp_reg <= RESP_DECERR;
      else
        rresp_reg <= RESP_OKAY;
    end
    else if (rready)
      rvalid_reg <= 1'b0;
  end

  assign awready = (wstate_reg == WS_IDLE) && !aw_held_reg;
  assign wready = (wstate_reg == WS_IDLE) && !w_held_reg;
  assign bvalid = (wstate_reg == WS_RESP);
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign sync_mode = sync_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_SEG2_LAST: assert property (
    wr_go && awidx_reg == SEG2_LAST_BASE |->
      wr_dec.region == RG_SEG && wr_dec.prog2 && wr_dec.seg == SEG_LAST)
    else $error("last segment of programmer two misdecoded");
  AST_RSVD_ERR: assert property (
    wr_go && wr_dec.region == RG_RSVD |=> bvalid && bresp == RESP_SLVERR)
    else $error("reserved write not refused");
  AST_SYNC_FOLLOW: assert property (
    sync_mode |-> prog2_active_program == prog1_active_program)
    else $error("programmer two does not follow one in sync mode");
  AST_SEL_LOAD: assert property (
    wr_go && wr_sel_en && !wr_dec.prog2 |=>
      prog1_active_program == $past(wr_val[PROG_W-1:0]))
    else $error("program select not applied");
  AST_PFA_OFF: assert property (
    wr_go && awidx_reg == PROG1_POWER_FAIL_ACTION_IDX |->
      wr_dec.region == RG_GEN && !wr_dec.prog2 && wr_dec.off == POWER_FAIL_ACTION_OFF)
    else $error("power fail action misdecoded");
  AST_TSP_OFF: assert property (
    wr_go && awidx_reg == PROG2_SEG1_TARGET_SETPOINT_IDX |->
      wr_dec.region == RG_SEG && wr_dec.seg == '0 && wr_dec.off == SEGMENT_TARGET_SETPOINT_OFF)
    else $error("target setpoint misdecoded");
  AST_ASYNC_OWN: assert property (
    !sync_mode |-> prog2_active_program == sel_reg[1][PROG_W-1:0])
    else $error("programmer two lost its own program");
  AST_SEL2_ISOL: assert property (
    wr_go && wr_dec.region == RG_GEN && wr_dec.prog2 |=> $stable(sel_reg[0]))
    else $error("programmer one select disturbed");
  AST_SEG_BASE: assert property (
    wr_go && awidx_reg == PROG1_SEG2_KIND_IDX |->
      wr_dec.region == RG_SEG && wr_dec.seg == 6'h01 && wr_dec.off == SEG_KIND_OFF)
    else $error("second segment base misdecoded");
  AST_GEN_BASE: assert property (
    wr_go && awidx_reg == PROG2_PROGRAM_SELECT_IDX |->
      wr_dec.region == RG_GEN && wr_dec.prog2 && wr_dec.off == PROGRAM_SELECT_OFF)
    else $error("general area base misdecoded");
  AST_RSVD_KEEP: assert property (
    wr_go && wr_dec.region == RG_RSVD |=> $stable(sync_reg) && $stable(sel_reg[1]))
    else $error("reserved write changed state");

  COV_RSVD: cover property (wr_go && wr_dec.region == RG_RSVD);
  COV_SYNC_SEG2: cover property (wr_go && sync_reg && wr_seg_en && wr_dec.prog2);
  COV_SEL2: cover property (wr_go && wr_sel_en && wr_dec.prog2);
  COV_READ: cover property (rvalid && rready && rresp == RESP_OKAY);

endmodule // pmap_regs
`default_nettype wire

//--- verif/pmap_master.sv
// axi4-lite master model of the supervisory comms side
`timescale 1ns/1ps
`default_nettype none
module pmap_master
  import pmap_pkg::*;
(
  input wire logic aclk, // clock
  output logic awvalid, // aw valid
  input wire logic awready, // aw ready
  output logic [ADDR_W-1:0] awaddr, // aw byte address
  output logic wvalid, // w valid
  input wire logic wready, // w ready
  output logic [31:0] wdata, // w data
  output logic [3:0] wstrb, // w strobes
  input wire logic bvalid, // b valid
  output logic bready, // b ready
  input wire logic [1:0] bresp, // b response
  output logic arvalid, // ar valid
  input wire logic arready, // ar ready
  output logic [ADDR_W-1:0] araddr, // ar byte address
  input wire logic rvalid, // r valid
  output logic rready, // r ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp // r response
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 32'h0000_0000;
    {wdata, wstrb} = 36'h0_0000_0000;
  end
  // released address and data lines flip so a stale value never passes for a live one
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= s;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid && bready)
      begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (rvalid && rready)
      begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule // pmap_master
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the programmer segment map register bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import pmap_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sync_mode;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [PROG_W-1:0] p1_act, p2_act;
  int fail_count = 0;
  int checks = 0;
  pmap_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .sync_mode(sync_mode), .prog1_active_program(p1_act), .prog2_active_program(p2_act));
  pmap_master u_mst (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_mst.wr(idx, d, 4'h3, r);
    chk_resp(r, er);
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_mst.rd(idx, d, r);
    chk_resp(r, er);
    chk_val(d, {16'h0000, ed});
  endtask
  task automatic chk_act(input logic [PROG_W-1:0] e1, input logic [PROG_W-1:0] e2);
    chk_val({30'h0000_0000, p1_act}, {30'h0000_0000, e1});
    chk_val({30'h0000_0000, p2_act}, {30'h0000_0000, e2});
  endtask
  task automatic t_reset;
    rd(CTRL_IDX, 16'h0000, RESP_OKAY);
    rd(PROG1_PROGRAM_SELECT_IDX, 16'h0000, RESP_OKAY);
    rd(PROG2_PROGRAM_SELECT_IDX, 16'h0000, RESP_OKAY);
    chk_val({31'h0000_0000, sync_mode}, 32'h0000_0000);
    chk_act(2'h0, 2'h0);
    $display("test reset done");
  endtask
  task automatic t_select;
    logic [1:0] r;
    wr(PROG1_PROGRAM_SELECT_IDX, 16'h0001, RESP_OKAY);
    wr(PROG2_PROGRAM_SELECT_IDX, 16'h0002, RESP_OKAY);
    chk_act(2'h1, 2'h2);
    rd(PROG1_PROGRAM_SELECT_IDX, 16'h0001, RESP_OKAY);
    wr(PROG1_POWER_FAIL_ACTION_IDX, 16'h1111, RESP_OKAY);
    wr(PROG2_POWER_FAIL_ACTION_IDX, 16'h2222, RESP_OKAY);
    rd(PROG1_POWER_FAIL_ACTION_IDX, 16'h1111, RESP_OKAY);
    rd(PROG2_POWER_FAIL_ACTION_IDX, 16'h2222, RESP_OKAY);
    wr(PROG1_PROGRAM_SELECT_IDX, 16'h0000, RESP_OKAY);
    wr(PROG1_POWER_FAIL_ACTION_IDX, 16'h3333, RESP_OKAY);
    wr(PROG1_PROGRAM_SELECT_IDX, 16'h0001, RESP_OKAY);
    rd(PROG1_POWER_FAIL_ACTION_IDX, 16'h1111, RESP_OKAY);
    wr(PROG1_PROGRAM_SELECT_IDX, 16'h0004, RESP_SLVERR);
    chk_act(2'h1, 2'h2);
    u_mst.wr(PROG2_POWER_FAIL_ACTION_IDX, 16'h55CC, 4'h1, r);
    chk_resp(r, RESP_OKAY);
    rd(PROG2_POWER_FAIL_ACTION_IDX, 16'h22CC, RESP_OKAY);
    $display("test select done");
  endtask
  task automatic t_segments;
    logic [IDX_W-1:0] a [8];
    a = '{PROG1_SEG1_KIND_IDX, PROG1_SEG1_TARGET_SETPOINT_IDX, PROG1_SEG2_KIND_IDX,
      PROG2_SEG1_KIND_IDX, PROG2_SEG1_TARGET_SETPOINT_IDX, PROG2_SEG2_KIND_IDX,
      SEG2_BASE + 14'h0300, SEG2_LAST_BASE + 14'h0006};
    for (int i = 0; i < 8; i++)
      wr(a[i], 16'h0100 + 16'(i), RESP_OKAY);
    for (int i = 0; i < 8; i++)
      rd(a[i], 16'h0100 + 16'(i), RESP_OKAY);
    $display("test segments done");
  endtask
  task automatic t_reserved;
    logic [IDX_W-1:0] a [4];
    a = '{SEG_RSVD_BASE, SEG_RSVD_LAST, GEN_RSVD_BASE, 14'h14FF};
    for (int i = 0; i < 4; i++)
    begin
      wr(a[i], 16'hDEAD, RESP_SLVERR);
      rd(a[i], 16'h0000, RESP_SLVERR);
    end
    wr(STATUS_IDX, 16'h0001, RESP_SLVERR);
    rd(14'h27C0, 16'h0000, RESP_DECERR);
    wr(14'h27C0, 16'h0001, RESP_DECERR);
    rd(SEG2_LAST_BASE + 14'h0006, 16'h0107, RESP_OKAY);
    rd(PROG1_SEG1_KIND_IDX, 16'h0100, RESP_OKAY);
    chk_act(2'h1, 2'h2);
    $display("test reserved done");
  endtask
  task automatic t_sync;
    wr(CTRL_IDX, 16'h0001, RESP_OKAY);
    chk_val({31'h0000_0000, sync_mode}, 32'h0000_0001);
    chk_act(2'h1, 2'h1);
    rd(STATUS_IDX, 16'h000B, RESP_OKAY);
    wr(PROG2_SEG1_TARGET_SETPOINT_IDX, 16'h7777, RESP_OKAY);
    rd(PROG2_SEG1_TARGET_SETPOINT_IDX, 16'h7777, RESP_OKAY);
    wr(CTRL_IDX, 16'h0000, RESP_OKAY);
    chk_act(2'h1, 2'h2);
    rd(PROG2_SEG1_TARGET_SETPOINT_IDX, 16'h0104, RESP_OKAY);
    wr(PROG2_PROGRAM_SELECT_IDX, 16'h0001, RESP_OKAY);
    rd(PROG2_SEG1_TARGET_SETPOINT_IDX, 16'h7777, RESP_OKAY);
    $display("test sync done");
  endtask
  task automatic finish_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // the whole sequence needs a few hundred cycles
  initial
  begin
    #100_000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_select();
    t_segments();
    t_reserved();
    t_sync();
    finish_test();
  end
endmodule // tb
`default_nettype wire
